// file: design/tac_pkg.sv
// constants and types for the touch converter command control
// assumes a single 100 MHz system clock for all control logic
package tac_pkg;
  localparam int SYS_HZ = 100_000_000;
  localparam int CCLK8_HZ = 4_000_000;
  localparam int CCLK12_HZ = 2_000_000;
  localparam logic [6:0] DIV8_CYC = 7'(SYS_HZ / CCLK8_HZ);
  localparam logic [6:0] DIV12_CYC = 7'(SYS_HZ / CCLK12_HZ);
  localparam logic [4:0] ACQ_CCLK = 5'h04;
  localparam logic [4:0] CONV12_CCLK = 5'h0f;
  localparam logic [4:0] CONV8_CCLK = 5'h0b;
  localparam logic [2:0] SAMPLES = 3'h7;
  localparam logic [2:0] AVG_FIRST = 3'h3;
  localparam logic [2:0] FIRST_ACQ_BIT = 3'h5;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [4:0] OUT_BITS = 5'h10;
  localparam int START_BIT = 7;
  localparam int RES_BIT = 3;
  localparam int REF_BIT = 2;
  localparam logic [2:0] CH_Y = 3'h1;
  localparam logic [2:0] CH_SETUP = 3'h2;
  localparam logic [2:0] CH_Z1 = 3'h3;
  localparam logic [2:0] CH_Z2 = 3'h4;
  localparam logic [2:0] CH_X = 3'h5;
  localparam logic [1:0] PD_RST = 2'h0;
  typedef struct packed {
    logic        res8;
    logic [11:0] code;
  } tac_result_type;
  typedef struct packed {
    logic [2:0] chan;
    logic       res8;
    logic       ref_single;
    logic [1:0] power_down_field;
  } tac_cmd_type;
  typedef struct packed {
    logic x_plus;
    logic x_minus;
    logic y_plus;
    logic y_minus;
  } tac_drv_type;
  typedef enum {
    ST_IDLE,
    ST_ACQ0,
    ST_CONV,
    ST_ACQ,
    ST_STORE
  } tac_state_type;
endpackage

// file: design/tac_control.sv
// command control of a resistive touch converter, with its result fifo
// assumes an spi mode 0 host on the pins and an external converter core
`timescale 1ns/100ps
`default_nettype none

module tac_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  // depth must be a power of two; pointers carry one wrap bit
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;
  assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem_q[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

module tac_control #(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         spi_sclk,
  input  wire logic         spi_cs_n,
  input  wire logic         spi_mosi,
  output logic              spi_miso,
  output logic              spi_miso_oe,
  input  wire logic         adjusted_timing,
  input  wire logic         filter_bypass,
  input  wire logic         pen_sense,
  input  wire logic [11:0]  adc_code,
  output logic              adc_power,
  output logic              adc_track,
  output logic              adc_convert,
  output logic              adc_res8,
  output logic              adc_ref_single,
  output tac_pkg::tac_drv_type drv,
  output logic              pen_touch_interrupt,
  output logic              busy
);
  import tac_pkg::*;
  logic [2:0]     sclk_sq;
  logic [1:0]     cs_n_sq;
  logic [1:0]     mosi_sq;
  logic [1:0]     pen_sq;
  logic           sel;
  logic           rise;
  logic           fall;
  logic [2:0]     bit_q;
  logic [7:0]     rx_q;
  logic [7:0]     new_byte;
  logic           byte_done;
  logic           cmd_valid;
  logic           acq0_go;
  tac_state_type  state_q;
  tac_cmd_type    cmd_q;
  logic           byp_q;
  logic [6:0]     div_q;
  logic           tick;
  logic [4:0]     cyc_q;
  logic [4:0]     conv_len;
  logic [2:0]     samp_q;
  logic [2:0]     samp_need;
  logic [13:0]    acc_q;
  logic [11:0]    last_q;
  logic [1:0]     pd_act_q;
  logic           hold_q;
  tac_drv_type    drv_d;
  tac_drv_type    chan_drv;
  logic           irq_en;
  tac_result_type res_in;
  tac_result_type res_out;
  logic           fifo_in_ready;
  logic           fifo_out_valid;
  logic           load;
  logic [15:0]    fmt;
  logic [15:0]    tx_q;
  logic [4:0]     tx_left_q;
  // pin synchronisers; only the second stage onward is looked at
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sclk_sq <= 3'h0;
      cs_n_sq <= 2'h3;
      mosi_sq <= 2'h0;
      pen_sq <= 2'h0;
    end else begin
      sclk_sq <= {sclk_sq[1:0], spi_sclk};
      cs_n_sq <= {cs_n_sq[0], spi_cs_n};
      mosi_sq <= {mosi_sq[0], spi_mosi};
      pen_sq <= {pen_sq[0], pen_sense};
    end
  end
  assign sel = !cs_n_sq[1];
  assign rise = sclk_sq[1] && !sclk_sq[2];
  assign fall = !sclk_sq[1] && sclk_sq[2];
  // byte framing; the bit count free-runs so any frame length works
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bit_q <= 3'h0;
      rx_q <= 8'h00;
    end else if (!sel) begin
      bit_q <= 3'h0;
    end else if (rise) begin
      bit_q <= bit_q + 3'h1;
      rx_q <= {rx_q[6:0], mosi_sq[1]};
    end
  end
  assign new_byte = {rx_q[6:0], mosi_sq[1]};
  assign byte_done = sel && rise && (bit_q == LAST_BIT);
  assign cmd_valid = byte_done && new_byte[START_BIT] && (new_byte[6:4] != CH_SETUP);
  // at the sixth rising edge the start bit and channel are already in
  assign acq0_go = sel && rise && (bit_q == FIRST_ACQ_BIT) && rx_q[4] && (rx_q[3:1] != CH_SETUP);
  // conversion clock as a divided tick of the system clock
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_q <= 7'h00;
    end else if (state_q == ST_IDLE || state_q == ST_ACQ0 || tick) begin
      div_q <= 7'h00;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end
  assign tick = (div_q == ((cmd_q.res8 ? DIV8_CYC : DIV12_CYC) - 7'h01));
  assign conv_len = cmd_q.res8 ? CONV8_CCLK : CONV12_CCLK;
  assign samp_need = byp_q ? 3'h1 : SAMPLES;
  // sequencer; a command arriving while busy is ignored
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      byp_q <= 1'b0;
      cyc_q <= 5'h00;
      samp_q <= 3'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (acq0_go) begin
            cmd_q.chan <= rx_q[3:1];
            state_q <= ST_ACQ0;
          end
        end
        ST_ACQ0: begin
          if (!sel) begin
            state_q <= ST_IDLE;
          end else if (cmd_valid) begin
            cmd_q.chan <= new_byte[6:4];
            cmd_q.res8 <= new_byte[RES_BIT];
            cmd_q.ref_single <= new_byte[REF_BIT];
            cmd_q.power_down_field <= new_byte[1:0];
            byp_q <= filter_bypass;
            cyc_q <= 5'h00;
            samp_q <= 3'h0;
            state_q <= ST_CONV;
          end else if (byte_done) begin
            state_q <= ST_IDLE;
          end
        end
        ST_CONV: begin
          if (tick) begin
            if (cyc_q == conv_len - 5'h01) begin
              cyc_q <= 5'h00;
              samp_q <= samp_q + 3'h1;
              if (samp_q == samp_need - 3'h1) begin
                state_q <= ST_STORE;
              end else begin
                state_q <= ST_ACQ;
              end
            end else begin
              cyc_q <= cyc_q + 5'h01;
            end
          end
        end
        ST_ACQ: begin
          if (tick) begin
            if (cyc_q == ACQ_CCLK - 5'h01) begin
              cyc_q <= 5'h00;
              state_q <= ST_CONV;
            end else begin
              cyc_q <= cyc_q + 5'h01;
            end
          end
        end
        ST_STORE: begin
          // a full fifo stalls the sequencer here
          if (fifo_in_ready) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
  // sample capture and averaging of the last four of seven
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      acc_q <= 14'h0000;
      last_q <= 12'h000;
    end else if (cmd_valid && state_q == ST_ACQ0) begin
      acc_q <= 14'h0000;
    end else if (state_q == ST_CONV && tick && cyc_q == conv_len - 5'h01) begin
      last_q <= adc_code;
      if (samp_q >= AVG_FIRST) begin
        acc_q <= acc_q + {2'h0, adc_code};
      end
    end
  end
  assign res_in.res8 = cmd_q.res8;
  assign res_in.code = byp_q ? last_q : acc_q[13:2];
  tac_fifo #(
    .WIDTH ($bits(tac_result_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (state_q == ST_STORE),
    .in_data   (res_in),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_ready (load),
    .out_data  (res_out)
  );
  // power-down mode and driver hold, taken over when the work is stored
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pd_act_q <= PD_RST;
      hold_q <= 1'b0;
    end else if (state_q == ST_STORE && fifo_in_ready) begin
      pd_act_q <= cmd_q.power_down_field;
      hold_q <= cmd_q.power_down_field[0] && sel;
    end else if (!sel ||
                 (cmd_valid && (new_byte[6:4] != cmd_q.chan || new_byte[1:0] != cmd_q.power_down_field))) begin
      hold_q <= 1'b0;
    end
  end
  always_comb begin
    chan_drv = '0;
    case (cmd_q.chan)
      CH_Y: begin
        chan_drv.y_plus = 1'b1;
        chan_drv.y_minus = 1'b1;
      end
      CH_Z1, CH_Z2: begin
        chan_drv.x_minus = 1'b1;
        chan_drv.y_plus = 1'b1;
      end
      CH_X: begin
        chan_drv.x_plus = 1'b1;
        chan_drv.x_minus = 1'b1;
      end
      default: begin
        chan_drv = '0;
      end
    endcase
  end
  assign irq_en = !pd_act_q[0];
  always_comb begin
    drv_d = '0;
    case (state_q)
      ST_ACQ0, ST_ACQ: begin
        drv_d = chan_drv;
      end
      ST_CONV: begin
        drv_d = cmd_q.ref_single ? tac_drv_type'(4'h0) : chan_drv;
      end
      ST_IDLE: begin
        if (hold_q) begin
          drv_d = chan_drv;
        end else if (irq_en) begin
          drv_d.y_minus = 1'b1;
        end
      end
      default: begin
        drv_d = '0;
      end
    endcase
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      drv <= '0;
      adc_power <= 1'b0;
      adc_track <= 1'b0;
      adc_convert <= 1'b0;
      adc_res8 <= 1'b0;
      adc_ref_single <= 1'b0;
      pen_touch_interrupt <= 1'b0;
      busy <= 1'b0;
    end else begin
      drv <= drv_d;
      // full power during work; afterwards only with the low bit set
      adc_power <= (state_q != ST_IDLE) || pd_act_q[0];
      adc_track <= (state_q == ST_ACQ0) || (state_q == ST_ACQ);
      adc_convert <= (state_q == ST_CONV);
      adc_res8 <= cmd_q.res8;
      adc_ref_single <= cmd_q.ref_single;
      pen_touch_interrupt <= irq_en && pen_sq[1] && (state_q == ST_IDLE) && !hold_q;
      busy <= (state_q != ST_IDLE) && (state_q != ST_ACQ0);
    end
  end
  // result shift-out; loads only at a byte boundary so framing stays fixed
  assign load = sel && fall && (bit_q == 3'h0) && (tx_left_q == 5'h00) && fifo_out_valid;
  assign fmt = res_out.res8 ? {res_out.code[11:4], 8'h00} : {res_out.code, 4'h0};
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_q <= 16'h0000;
      tx_left_q <= 5'h00;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= sel;
      if (!sel) begin
        tx_q <= 16'h0000;
        tx_left_q <= 5'h00;
        spi_miso <= 1'b0;
      end else if (load && adjusted_timing) begin
        spi_miso <= fmt[15];
        tx_q <= {fmt[14:0], 1'b0};
        tx_left_q <= OUT_BITS - 5'h01;
      end else if (load) begin
        spi_miso <= 1'b0;
        tx_q <= fmt;
        tx_left_q <= OUT_BITS;
      end else if (fall) begin
        spi_miso <= tx_q[15];
        tx_q <= {tx_q[14:0], 1'b0};
        if (tx_left_q != 5'h00) begin
          tx_left_q <= tx_left_q - 5'h01;
        end
      end
    end
  end
endmodule

`default_nettype wire

// file: tb/tac_control_assertions.sv
// concurrent checks on the touch converter command control
// bound into tac_control; sees only its ports
`timescale 1ns/100ps
`default_nettype none
module tac_control_assertions
  import tac_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic                clk_sys,
  input wire logic                reset,
  input wire logic                spi_sclk,
  input wire logic                spi_cs_n,
  input wire logic                spi_mosi,
  input wire logic                spi_miso,
  input wire logic                spi_miso_oe,
  input wire logic                adjusted_timing,
  input wire logic                filter_bypass,
  input wire logic                pen_sense,
  input wire logic [11:0]         adc_code,
  input wire logic                adc_power,
  input wire logic                adc_track,
  input wire logic                adc_convert,
  input wire logic                adc_res8,
  input wire logic                adc_ref_single,
  input wire tac_pkg::tac_drv_type drv,
  input wire logic                pen_touch_interrupt,
  input wire logic                busy
);
  localparam int C12 = int'(CONV12_CCLK) * int'(DIV12_CYC);
  localparam int C8 = int'(CONV8_CCLK) * int'(DIV8_CYC);
  logic [11:0] conv_len_q;
  logic [11:0] conv_want;
  logic [3:0]  conv_num_q;
  // a couple of cycles of slack for the divider phase, far below one cclk
  assign conv_want = adc_res8 ? 12'(C8) : 12'(C12);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      conv_len_q <= 12'h000;
    else
      conv_len_q <= adc_convert ? conv_len_q + 12'h001 : 12'h000;
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      conv_num_q <= 4'h0;
    else if ($rose(busy))
      conv_num_q <= {3'h0, $rose(adc_convert)};
    else if ($rose(adc_convert))
      conv_num_q <= conv_num_q + 4'h1;
  end
  default clocking dclk @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  a_se_drv_off: assert property (adc_convert && adc_ref_single |-> drv == 4'h0)
    else $error("drivers on in single-ended conversion");
  a_dfr_drv_on: assert property (adc_convert && !adc_ref_single |-> drv != 4'h0)
    else $error("drivers off in differential conversion");
  a_busy_powered: assert property (busy |-> adc_power)
    else $error("converter unpowered while busy");
  a_irq_off_powered: assert property (adc_power |-> !pen_touch_interrupt)
    else $error("pen interrupt while converter powered");
  a_conv_length: assert property ($fell(adc_convert) |->
    conv_len_q + 12'h002 >= conv_want && conv_len_q <= conv_want + 12'h002)
    else $error("conversion phase length wrong");
  a_sample_count: assert property ($fell(busy) |->
    conv_num_q == (filter_bypass ? 4'h1 : {1'b0, SAMPLES}))
    else $error("wrong number of conversions");
  a_acq_then_conv: assert property ($fell(adc_track) && busy |-> adc_convert)
    else $error("acquisition not followed by conversion");
  a_deselect_quiet: assert property (spi_cs_n [*6] |-> !spi_miso_oe && !spi_miso)
    else $error("serial output active while deselected");
endmodule
bind tac_control tac_control_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) tac_control_assertions_inst (
  .clk_sys(clk_sys), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
  .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
  .adjusted_timing(adjusted_timing), .filter_bypass(filter_bypass),
  .pen_sense(pen_sense), .adc_code(adc_code), .adc_power(adc_power),
  .adc_track(adc_track), .adc_convert(adc_convert), .adc_res8(adc_res8),
  .adc_ref_single(adc_ref_single), .drv(drv),
  .pen_touch_interrupt(pen_touch_interrupt), .busy(busy)
);
`default_nettype wire

// file: tb/tac_spi_host.sv
// behavioural spi mode 0 host driving the converter control
// assumes clk_sys is the 100 MHz system clock of the bench
`timescale 1ns/100ps
`default_nettype none
module tac_spi_host (
  input  wire logic clk_sys,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // five cycles leaves margin over the slowest sampling the synchronisers tolerate
  task automatic half();
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic select(input logic on);
    @(posedge clk_sys);
    spi_cs_n <= !on;
    if (!on)
      spi_mosi <= !spi_mosi;
    half();
  endtask
  // sclk stands low between bytes; frames are built from whole bytes
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk_sys);
      spi_mosi <= tx[i];
      half();
      spi_sclk <= 1'b1;
      rx[i] = spi_miso;
      half();
      spi_sclk <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: tb/tac_control_tb.sv
// self-checking bench for the touch converter command control
// host model on the serial pins, converter core modelled by adc_code
`timescale 1ns/100ps
`default_nettype none
module tac_control_tb;
  import tac_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        spi_sclk;
  logic        spi_cs_n;
  logic        spi_mosi;
  logic        spi_miso;
  logic        spi_miso_oe;
  logic        adjusted_timing = 1'b0;
  logic        filter_bypass = 1'b1;
  logic        pen_sense = 1'b0;
  logic [11:0] adc_code = 12'h000;
  logic        adc_power;
  logic        adc_track;
  logic        adc_convert;
  logic        adc_res8;
  logic        adc_ref_single;
  tac_drv_type drv;
  logic        pen_touch_interrupt;
  logic        busy;
  int          num_errors = 0;
  int          checks = 0;
  logic [15:0] seed = 16'h0032;
  logic [7:0]  rx;
  int          exp_q[$];
  // x diff 12-bit, y single 8-bit, z1 diff 12-bit, z2 single 8-bit
  logic [7:0]  cmd[4] = '{8'hd0, 8'h9d, 8'hb2, 8'hcf};
  logic        adj[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic        byp[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic        desel[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  logic [3:0]  edrv[4] = '{4'h1, 4'h3, 4'h1, 4'h6};
  always #5 clk_sys = ~clk_sys;
  tac_control #(.FIFO_DEPTH(32)) tac_control_inst (
    .clk_sys(clk_sys), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .adjusted_timing(adjusted_timing), .filter_bypass(filter_bypass),
    .pen_sense(pen_sense), .adc_code(adc_code), .adc_power(adc_power),
    .adc_track(adc_track), .adc_convert(adc_convert), .adc_res8(adc_res8),
    .adc_ref_single(adc_ref_single), .drv(drv),
    .pen_touch_interrupt(pen_touch_interrupt), .busy(busy)
  );
  tac_spi_host tac_spi_host_inst (
    .clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso)
  );
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // result word: msb first, padded with zeros to sixteen bits
  function automatic int word_of(input logic [11:0] c, input logic r8);
    return r8 ? {16'h0, c[11:4], 8'h00} : {16'h0, c, 4'h0};
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= lim) begin
      check("busy", 16'(lvl), 16'(busy));
      final_report();
    end
  endtask
  // compatible timing leads with a zero bit, so the last bit falls off
  task automatic read_word();
    logic [15:0] got;
    logic [15:0] exp;
    tac_spi_host_inst.xfer(8'h00, got[15:8]);
    tac_spi_host_inst.xfer(8'h00, got[7:0]);
    exp = 16'h0000;
    if (exp_q.size() > 0) begin
      exp = 16'(exp_q.pop_front());
      if (!adjusted_timing)
        exp = exp >> 1;
    end
    check("result", exp, got);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check("idle drv", 16'h1, 16'(drv));
    check("irq", 16'h0, 16'(pen_touch_interrupt));
    pen_sense <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check("irq", 16'h1, 16'(pen_touch_interrupt));
    tac_spi_host_inst.select(1'b1);
    tac_spi_host_inst.xfer(8'h50, rx);
    tac_spi_host_inst.xfer(8'ha0, rx);
    repeat (50) @(posedge clk_sys);
    check("busy", 16'h0, 16'(busy));
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      adc_code <= seed[11:0];
      adjusted_timing <= adj[i];
      filter_bypass <= byp[i];
      if (spi_cs_n)
        tac_spi_host_inst.select(1'b1);
      tac_spi_host_inst.xfer(cmd[i], rx);
      wait_busy(1'b1, 100);
      check("res8", 16'(cmd[i][3]), 16'(adc_res8));
      check("ref", 16'(cmd[i][2]), 16'(adc_ref_single));
      check("oe", 16'h1, 16'(spi_miso_oe));
      read_word();
      exp_q.push_back(word_of(seed[11:0], cmd[i][3]));
      if (desel[i])
        tac_spi_host_inst.select(1'b0);
      wait_busy(1'b0, 8000);
      repeat (2) @(posedge clk_sys);
      check("power", 16'(cmd[i][0]), 16'(adc_power));
      check("irq", 16'(!cmd[i][0]), 16'(pen_touch_interrupt));
      check("drv", 16'(edrv[i]), 16'(drv));
    end
    tac_spi_host_inst.xfer(8'h00, rx);
    read_word();
    tac_spi_host_inst.select(1'b0);
    repeat (6) @(posedge clk_sys);
    check("drv", 16'h0, 16'(drv));
    check("oe", 16'h0, 16'(spi_miso_oe));
    final_report();
  end
endmodule
`default_nettype wire
